// ==== common/pdw_pkg.sv ====
// Constants for the process data watchdog register block
package pdw_pkg;
  // Register word addresses
  localparam logic [15:0] PDW_ADDR_TIMEOUT = 16'h07d0;
  localparam logic [15:0] PDW_ADDR_MODE = 16'h07d2;
  localparam logic [15:0] PDW_ADDR_REASON = 16'h07d4;
  localparam logic [15:0] PDW_ADDR_COMMAND = 16'h07d6;
  localparam logic [15:0] PDW_ADDR_STATUS = 16'h1f3c;
  // Reset values
  localparam logic [15:0] PDW_RST_TIMEOUT = 16'h0000;
  localparam logic [1:0] PDW_RST_MODE = 2'h0;
  localparam logic [15:0] PDW_RST_REASON = 16'h0000;
  localparam logic [7:0] PDW_RST_DOUT = 8'h00;
  // Timeout limits in milliseconds
  localparam logic [15:0] PDW_TMO_OFF = 16'h0000;
  localparam logic [15:0] PDW_TMO_MIN_MS = 16'd200;
  localparam logic [15:0] PDW_TMO_MAX_MS = 16'd65000;
  // Fault response modes
  localparam logic [1:0] PDW_MODE_LOW = 2'h0;
  localparam logic [1:0] PDW_MODE_HIGH = 2'h1;
  localparam logic [1:0] PDW_MODE_HOLD = 2'h2;
  // Fault reason codes
  localparam logic [15:0] PDW_RSN_USER = 16'h0009;
  localparam logic [15:0] PDW_RSN_WD = 16'h000c;
  // Command bit positions
  localparam int PDW_CMD_SET_FAIL = 4;
  localparam int PDW_CMD_ACK_FAIL = 5;
  localparam int PDW_CMD_CLR_WARN = 7;
  // Status bit positions
  localparam int PDW_STAT_ERROR = 0;
  localparam int PDW_STAT_NET_FAIL = 1;
endpackage : pdw_pkg

// ==== src/pdw_regs.sv ====
// Process data watchdog, fault response and status registers
`timescale 1ns/1ps
module pdw_regs
  import pdw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ms_tick,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  input wire logic pd_wr,
  input wire logic [7:0] pd_wdata,
  output logic [7:0] dout,
  output logic net_fail,
  input wire logic auto_ack,
  input wire logic ext_fault,
  input wire logic [15:0] ext_fault_code,
  input wire logic diag_error,
  input wire logic io_warn,
  output logic io_warn_latched
);

  typedef struct packed {
    logic [15:0] timeout;
    logic [1:0] mode;
    logic [15:0] reason;
    logic [15:0] cnt;
    logic wd_run;
    logic fail;
    logic warn;
    logic [7:0] pd;
    logic [7:0] dout;
    logic [15:0] rdata;
    logic ack;
    logic err;
  } pdw_state_type;

  pdw_state_type r;
  pdw_state_type next_r;

  logic wr_tmo;
  logic wr_mode;
  logic wr_cmd;
  logic cmd_one;
  logic tmo_ok;
  logic wd_expire;
  logic [15:0] status;

  // Decoded requests
  assign wr_tmo = reg_wr && reg_addr == PDW_ADDR_TIMEOUT;
  assign wr_mode = reg_wr && reg_addr == PDW_ADDR_MODE;
  assign wr_cmd = reg_wr && reg_addr == PDW_ADDR_COMMAND;
  assign cmd_one = $countones(reg_wdata) == 1;
  // Zero is legal only before the watchdog runs
  assign tmo_ok = (reg_wdata == PDW_TMO_OFF) ? !r.wd_run
                  : (reg_wdata >= PDW_TMO_MIN_MS && reg_wdata <= PDW_TMO_MAX_MS);
  // Expiry on the tick that reaches the timeout
  assign wd_expire = r.wd_run && !r.fail && ms_tick && r.timeout != PDW_TMO_OFF
                     && (r.cnt + 16'h0001) >= r.timeout;

  // Status word, reserved bits zero
  always_comb begin
    status = 16'h0000;
    status[PDW_STAT_ERROR] = diag_error || r.warn || r.fail;
    status[PDW_STAT_NET_FAIL] = r.fail;
  end

  // Next state
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    next_r.rdata = 16'h0000;
    // Register bus requests
    if (reg_wr) begin
      next_r.ack = 1'b1;
      if (wr_tmo) begin
        if (tmo_ok) begin
          next_r.timeout = reg_wdata;
        end else begin
          next_r.err = 1'b1;
        end
      end else if (wr_mode) begin
        if (reg_wdata <= 16'h0002) begin
          next_r.mode = reg_wdata[1:0];
        end else begin
          next_r.err = 1'b1;
        end
      end else if (wr_cmd) begin
        if (!cmd_one) begin
          next_r.err = 1'b1;
        end
      end else begin
        next_r.err = 1'b1;
      end
    end else if (reg_rd) begin
      next_r.ack = 1'b1;
      unique case (reg_addr)
        PDW_ADDR_TIMEOUT: next_r.rdata = r.timeout;
        PDW_ADDR_MODE: next_r.rdata = {14'h0000, r.mode};
        PDW_ADDR_REASON: next_r.rdata = r.reason;
        PDW_ADDR_STATUS: next_r.rdata = status;
        default: next_r.err = 1'b1;
      endcase
    end
    // Watchdog counting
    if (r.wd_run && !r.fail && ms_tick) begin
      next_r.cnt = r.cnt + 16'h0001;
    end
    // Output process data write triggers the watchdog
    if (pd_wr) begin
      next_r.pd = pd_wdata;
      if (!r.fail && r.timeout != PDW_TMO_OFF) begin
        next_r.wd_run = 1'b1;
        next_r.cnt = 16'h0000;
      end
      if (r.fail && auto_ack) begin
        next_r.fail = 1'b0;
        next_r.cnt = 16'h0000;
        next_r.wd_run = r.timeout != PDW_TMO_OFF;
      end
    end
    // Commands, only with a single bit set
    if (wr_cmd && cmd_one) begin
      if (reg_wdata[PDW_CMD_ACK_FAIL] && r.fail) begin
        next_r.fail = 1'b0;
        next_r.cnt = 16'h0000;
        next_r.wd_run = r.timeout != PDW_TMO_OFF;
      end
      if (reg_wdata[PDW_CMD_SET_FAIL]) begin
        next_r.fail = 1'b1;
        next_r.reason = PDW_RSN_USER;
      end
    end
    // Warning latch, set wins over clear
    next_r.warn = (r.warn && !(wr_cmd && cmd_one && reg_wdata[PDW_CMD_CLR_WARN]))
                  || io_warn;
    // Fault sources, set wins over acknowledge
    if (ext_fault) begin
      next_r.fail = 1'b1;
      next_r.reason = ext_fault_code;
    end
    if (wd_expire) begin
      next_r.fail = 1'b1;
      next_r.reason = PDW_RSN_WD;
    end
    // Output drive
    if (!next_r.fail) begin
      next_r.dout = next_r.pd;
    end else begin
      unique case (next_r.mode)
        PDW_MODE_LOW: next_r.dout = 8'h00;
        PDW_MODE_HIGH: next_r.dout = 8'hff;
        default: next_r.dout = r.dout;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.timeout <= PDW_RST_TIMEOUT;
      r.mode <= PDW_RST_MODE;
      r.reason <= PDW_RST_REASON;
      r.dout <= PDW_RST_DOUT;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Outputs straight from state
  assign reg_rdata = r.rdata;
  assign reg_ack = r.ack;
  assign reg_err = r.err;
  assign dout = r.dout;
  assign net_fail = r.fail;
  assign io_warn_latched = r.warn;

  // Zero timeout never raises a watchdog fault
  property p_zero_off;
    @(posedge clk) disable iff (rst)
      r.timeout == PDW_TMO_OFF && !r.fail && !ext_fault |=> !(r.fail && r.reason == PDW_RSN_WD);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("expiry with zero timeout");

  // Expiry sets fault and reason
  property p_wd_reason;
    @(posedge clk) disable iff (rst) ce && wd_expire |=> r.fail && r.reason == PDW_RSN_WD;
  endproperty
  a_wd_reason: assert property (p_wd_reason) else $error("expiry reason wrong");

  // Multi-bit command errors
  property p_cmd_multi;
    @(posedge clk) disable iff (rst)
      ce && wr_cmd && $countones(reg_wdata) > 1 |=> r.ack && r.err;
  endproperty
  a_cmd_multi: assert property (p_cmd_multi) else $error("multi-bit command accepted");

  // Command reads refused
  property p_cmd_read;
    @(posedge clk) disable iff (rst)
      ce && reg_rd && !reg_wr && reg_addr == PDW_ADDR_COMMAND |=> r.err && r.rdata == 16'h0000;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read not refused");

  // Low mode drives zeros during fault
  property p_mode_low;
    @(posedge clk) disable iff (rst) r.fail && r.mode == PDW_MODE_LOW |-> r.dout == 8'h00;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("low substitute not driven");

  // Hold mode keeps outputs
  property p_mode_hold;
    @(posedge clk) disable iff (rst)
      r.fail && $past(r.fail) && r.mode == PDW_MODE_HOLD && $past(r.mode) == PDW_MODE_HOLD
      |-> $stable(r.dout);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("hold outputs changed");

  // Out of range timeout rejected
  property p_tmo_range;
    @(posedge clk) disable iff (rst)
      ce && wr_tmo && reg_wdata != PDW_TMO_OFF
      && (reg_wdata < PDW_TMO_MIN_MS || reg_wdata > PDW_TMO_MAX_MS)
      |=> $stable(r.timeout) && r.err;
  endproperty
  a_tmo_range: assert property (p_tmo_range) else $error("bad timeout accepted");

  // Output write restarts the count
  property p_restart;
    @(posedge clk) disable iff (rst)
      ce && pd_wr && !r.fail && r.timeout != PDW_TMO_OFF && !ext_fault |=> r.cnt == 16'h0000 && r.wd_run;
  endproperty
  a_restart: assert property (p_restart) else $error("watchdog not restarted");

  // Running watchdog never stops
  property p_no_stop;
    @(posedge clk) disable iff (rst) r.wd_run && r.timeout != PDW_TMO_OFF |=> r.wd_run;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("watchdog stopped");

endmodule // pdw_regs

// ==== verification/pdw_client.sv ====
// Behavioural client that writes output process data
`timescale 1ns/1ps
module pdw_client (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] data,
  output logic pd_wr,
  output logic [7:0] pd_wdata
);
  initial begin
    pd_wr = 1'b0;
    pd_wdata = 8'h00;
  end
  // One write per request, data scrambled while idle
  always @(negedge clk) begin
    pd_wr <= send;
    pd_wdata <= send ? data : ~pd_wdata;
  end
endmodule // pdw_client

// ==== verification/tb_pdw_regs.sv ====
// Testbench for the process data watchdog register block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_pdw_regs;
  import pdw_pkg::*;
  logic clk = 0, rst = 1, ms_tick = 0, tick_en = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
  logic reg_ack, reg_err, pd_wr, send = 0, net_fail, auto_ack = 0;
  logic diag_error = 0, io_warn = 0, io_warn_latched, ext_fault = 0;
  logic [15:0] ext_fault_code = 16'h0;
  logic [7:0] pd_wdata, dout, sdata = 8'h00;
  int num_errors = 0, check_count = 0;
  always #2.5 clk = ~clk;
  // Millisecond tick every second cycle
  always @(negedge clk) ms_tick <= tick_en & ~ms_tick;
  pdw_client CLI (.clk(clk), .send(send), .data(sdata), .pd_wr(pd_wr), .pd_wdata(pd_wdata));
  pdw_regs DUT (.clk(clk), .rst(rst), .ce(1'b1), .ms_tick(ms_tick), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .pd_wr(pd_wr), .pd_wdata(pd_wdata), .dout(dout),
    .net_fail(net_fail), .auto_ack(auto_ack), .ext_fault(ext_fault),
    .ext_fault_code(ext_fault_code),
    .diag_error(diag_error), .io_warn(io_warn), .io_warn_latched(io_warn_latched));
  // One register access, checks error flag and read data
  task automatic acc(input logic w, input logic [15:0] a, d, input logic e,
      input logic [15:0] r);
    @(negedge clk);
    reg_wr = w;
    reg_rd = ~w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
    reg_rd = 0;
    `CHK(reg_ack, 1'b1)
    `CHK(reg_err, e)
    if (!w && !e) `CHK(reg_rdata, r)
  endtask
  // One output process data write through the client
  task automatic pd(input logic [7:0] d);
    @(posedge clk);
    sdata <= d;
    send <= 1;
    @(posedge clk);
    send <= 0;
  endtask
  task automatic s_reset;
    acc(0, PDW_ADDR_TIMEOUT, 16'h0, 0, PDW_RST_TIMEOUT);
    acc(0, PDW_ADDR_MODE, 16'h0, 0, 16'h0000);
    acc(0, PDW_ADDR_REASON, 16'h0, 0, PDW_RST_REASON);
    acc(0, PDW_ADDR_COMMAND, 16'h0, 1, 16'h0);
    acc(0, 16'h0123, 16'h0, 1, 16'h0);
    acc(1, PDW_ADDR_REASON, 16'h0001, 1, 16'h0);
    pd(8'h5a);
    repeat (600) @(negedge clk);
    `CHK(net_fail, 1'b0)
    `CHK(dout, 8'h5a)
  endtask
  task automatic s_cmd;
    acc(1, PDW_ADDR_COMMAND, 16'h0030, 1, 16'h0);
    `CHK(net_fail, 1'b0)
    acc(1, PDW_ADDR_COMMAND, 16'h0001, 0, 16'h0);
    acc(1, PDW_ADDR_COMMAND, 16'h0010, 0, 16'h0);
    `CHK(dout, 8'h00)
    acc(0, PDW_ADDR_STATUS, 16'h0, 0, 16'h0003);
    acc(0, PDW_ADDR_REASON, 16'h0, 0, PDW_RSN_USER);
    acc(1, PDW_ADDR_COMMAND, 16'h0020, 0, 16'h0);
    `CHK(dout, 8'h5a)
    acc(0, PDW_ADDR_STATUS, 16'h0, 0, 16'h0000);
    // Outside fault source loads its own reason code
    ext_fault_code = 16'h000a;
    ext_fault = 1;
    @(negedge clk);
    ext_fault = 0;
    `CHK(net_fail, 1'b1)
    acc(0, PDW_ADDR_REASON, 16'h0, 0, 16'h000a);
    acc(1, PDW_ADDR_COMMAND, 16'h0020, 0, 16'h0);
    `CHK(net_fail, 1'b0)
  endtask
  task automatic s_warn;
    @(negedge clk);
    io_warn = 1;
    @(negedge clk);
    io_warn = 0;
    `CHK(io_warn_latched, 1'b1)
    acc(0, PDW_ADDR_STATUS, 16'h0, 0, 16'h0001);
    acc(1, PDW_ADDR_COMMAND, 16'h0080, 0, 16'h0);
    `CHK(io_warn_latched, 1'b0)
    diag_error = 1;
    acc(0, PDW_ADDR_STATUS, 16'h0, 0, 16'h0001);
    diag_error = 0;
  endtask
  task automatic s_range;
    acc(1, PDW_ADDR_TIMEOUT, 16'd199, 1, 16'h0);
    acc(1, PDW_ADDR_TIMEOUT, 16'd65001, 1, 16'h0);
    acc(1, PDW_ADDR_TIMEOUT, 16'd65000, 0, 16'h0);
    acc(0, PDW_ADDR_TIMEOUT, 16'h0, 0, 16'd65000);
    acc(1, PDW_ADDR_MODE, 16'h0003, 1, 16'h0);
    acc(1, PDW_ADDR_TIMEOUT, 16'd200, 0, 16'h0);
  endtask
  // Expiry in each mode, acked by command or by auto acknowledge
  task automatic s_watch;
    logic [7:0] sub_val [3] = '{8'h00, 8'hff, 8'ha5};
    for (int m = 0; m < 3; m++) begin
      auto_ack = (m == 1);
      acc(1, PDW_ADDR_MODE, 16'(m), 0, 16'h0);
      pd(8'ha5);
      repeat (200) @(negedge clk);
      acc(0, PDW_ADDR_STATUS, 16'h0, 0, 16'h0000);
      repeat (190) @(negedge clk);
      `CHK(net_fail, 1'b0)
      repeat (12) @(negedge clk);
      `CHK(net_fail, 1'b1)
      `CHK(dout, sub_val[m])
      acc(0, PDW_ADDR_REASON, 16'h0, 0, PDW_RSN_WD);
      acc(1, PDW_ADDR_TIMEOUT, 16'h0, 1, 16'h0);
      if (m == 1) pd(8'h3c);
      else acc(1, PDW_ADDR_COMMAND, 16'h0020, 0, 16'h0);
      @(negedge clk);
      `CHK(net_fail, 1'b0)
    end
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    tick_en = 1;
    s_reset;
    s_cmd;
    s_warn;
    s_range;
    s_watch;
    results;
  end
  // Hang guard
  initial begin
    #40000;
    num_errors++;
    results;
  end
endmodule // tb_pdw_regs
